//--- shared/thermal_pg_pkg.sv
// Shared constants and types for the thermal threshold and rail-good register bank.
// Assumes a serial-bus engine elsewhere turns host transfers into register requests.
`default_nettype none
package thermal_pg_pkg;
  // Register byte addresses
  localparam logic [7:0] THRESH_ADDR = 8'h0e;
  localparam logic [7:0] STATUS_ADDR = 8'h0f;
  localparam logic [7:0] SILICON_REVISION_ID_ADDR = 8'h10;
  // Reset values
  localparam logic [7:0] THRESH_RESET = 8'h78;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Threshold fields
  localparam int COLD_MSB = 7;
  localparam int COLD_LSB = 4;
  localparam int HOT_MSB = 3;
  localparam int HOT_LSB = 0;
  // Code-to-degree offsets
  localparam logic signed [7:0] COLD_BASE_C = -8'sd7;
  localparam logic signed [7:0] HOT_BASE_C = 8'sd42;
  // Status bit positions
  localparam int BOOST_BIT = 7;
  localparam int POS_GATE_BIT = 6;
  localparam int INVERT_BIT = 5;
  localparam int POS_SRC_BIT = 4;
  localparam int NEG_GATE_BIT = 3;
  localparam int NEG_SRC_BIT = 1;
  // Revision fields
  localparam int MAJOR_MSB = 7;
  localparam int MAJOR_LSB = 6;
  localparam int MINOR_MSB = 5;
  localparam int MINOR_LSB = 4;
  localparam int VERSION_MSB = 3;
  localparam int VERSION_LSB = 0;
  localparam int NUM_RAILS = 6;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic pos_boost_good;
    logic pos_gate_pump_good;
    logic inverting_converter_good;
    logic pos_source_reg_good;
    logic neg_gate_pump_good;
    logic neg_source_reg_good;
  } rail_good_t;
endpackage
`default_nettype wire

//--- design/rail_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous rail-good levels.
// Assumes inputs come straight from analog comparators, unrelated to sys_clk.
`default_nettype none
module rail_sync #(
  parameter int WIDTH = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] held_ff;
  logic [WIDTH-1:0] agree;

  // A change is accepted only once two later stages agree, filtering single glitches
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign agree[i] = (s2_ff[i] == s3_ff[i]);
    end
  endgenerate

  // One process owns every stage, so no flop vector has several writers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      held_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      held_ff <= (held_ff & ~agree) | (s3_ff & agree);
    end
  end

  assign sync_out = held_ff;
endmodule // rail_sync
`default_nettype wire

//--- design/thermal_threshold_powergood_regs.sv
// Thermal alarm thresholds, rail-good status, power-good pin and revision register.
// Assumes a serial-bus engine on sys_clk issues register requests and temperature
// readings arrive as a one-cycle strobe with a signed whole-degree value.
`default_nettype none
module thermal_threshold_powergood_regs
  import thermal_pg_pkg::*;
#(
  // Arbitrary neutral value, not tied to any real part
  parameter logic [1:0] MAJOR_REV = 2'h1,
  parameter logic [1:0] MINOR_REV = 2'h0,
  parameter logic [3:0] VERSION_CODE = 4'h3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic temp_done,
  input wire logic signed [7:0] temp_value,
  input wire rail_good_t rail_good_async,
  output logic cold_alarm,
  output logic hot_alarm,
  output logic rail_good_output_o,
  output logic rail_good_output_oe_n
);
  logic [7:0] thresh_ff;
  logic [7:0] nxt_thresh;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic cold_ff;
  logic hot_ff;
  logic pg_oe_n_ff;
  logic [NUM_RAILS-1:0] rails_sync;
  rail_good_t rails;
  logic [7:0] status_word;
  logic [7:0] silicon_revision_id_word;
  logic signed [7:0] cold_deg;
  logic signed [7:0] hot_deg;
  logic cold_hit;
  logic hot_hit;
  logic all_gate_src_good;
  logic [2:0] reg_sel;
  logic sel_thresh;
  logic sel_status;
  logic sel_silicon_revision_id;
  logic wr_thresh;
  logic rd_strobe;
  logic [3:0] cold_code;
  logic [3:0] hot_code;
  logic cold_event;
  logic hot_event;

  // One-hot register select shared by the write path and the read mux
  function automatic logic [2:0] decode_addr(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    sel[0] = (addr == THRESH_ADDR);
    sel[1] = (addr == STATUS_ADDR);
    sel[2] = (addr == SILICON_REVISION_ID_ADDR);
    return sel;
  endfunction

  // Codes are unsigned, so they are zero-extended before the signed offset is added
  function automatic logic signed [7:0] code_to_deg(input logic [3:0] code,
                                                    input logic signed [7:0] base);
    return $signed({4'h0, code}) + base;
  endfunction

  // Rail-good levels come from analog comparators, so they are synchronised first
  rail_sync #(
    .WIDTH(NUM_RAILS)
  ) u_rail_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(rail_good_async),
    .sync_out(rails_sync)
  );
  assign rails = rail_good_t'(rails_sync);

  always_comb begin
    status_word = STATUS_RESET;
    status_word[BOOST_BIT] = rails.pos_boost_good;
    status_word[POS_GATE_BIT] = rails.pos_gate_pump_good;
    status_word[INVERT_BIT] = rails.inverting_converter_good;
    status_word[POS_SRC_BIT] = rails.pos_source_reg_good;
    status_word[NEG_GATE_BIT] = rails.neg_gate_pump_good;
    status_word[NEG_SRC_BIT] = rails.neg_source_reg_good;
  end

  always_comb begin
    silicon_revision_id_word = 8'h00;
    silicon_revision_id_word[MAJOR_MSB:MAJOR_LSB] = MAJOR_REV;
    silicon_revision_id_word[MINOR_MSB:MINOR_LSB] = MINOR_REV;
    silicon_revision_id_word[VERSION_MSB:VERSION_LSB] = VERSION_CODE;
  end

  assign reg_sel = decode_addr(reg_req.addr);
  assign sel_thresh = reg_sel[0];
  assign sel_status = reg_sel[1];
  assign sel_silicon_revision_id = reg_sel[2];
  assign wr_thresh = reg_req.wr & sel_thresh;
  assign rd_strobe = reg_req.rd;

  assign nxt_thresh = wr_thresh ? reg_req.wdata : thresh_ff;

  // Unmapped addresses read as zero rather than aliasing
  // A read in the same cycle as a write returns the old threshold
  assign nxt_rdata = sel_thresh ? thresh_ff :
                     sel_status ? status_word :
                     sel_silicon_revision_id ? silicon_revision_id_word : 8'h00;

  assign cold_code = thresh_ff[COLD_MSB:COLD_LSB];
  assign hot_code = thresh_ff[HOT_MSB:HOT_LSB];
  assign cold_deg = code_to_deg(cold_code, COLD_BASE_C);
  assign hot_deg = code_to_deg(hot_code, HOT_BASE_C);
  assign cold_hit = temp_value <= cold_deg;
  assign hot_hit = temp_value >= hot_deg;
  assign cold_event = temp_done & cold_hit;
  assign hot_event = temp_done & hot_hit;

  assign all_gate_src_good = rails.pos_gate_pump_good & rails.pos_source_reg_good &
                             rails.neg_gate_pump_good & rails.neg_source_reg_good;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thresh_ff <= THRESH_RESET;
    end else begin
      thresh_ff <= nxt_thresh;
    end
  end

  // Answer strobe stands for exactly one cycle after each read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= rd_strobe;
    end
  end

  // Read data holds until the next read, so a slow host can pick it up late
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (rd_strobe) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Alarms are pulses; latching them is left to the interrupt logic outside
  // cold alarm pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cold_ff <= 1'b0;
    end else begin
      cold_ff <= cold_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hot_ff <= 1'b0;
    end else begin
      hot_ff <= hot_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pg_oe_n_ff <= 1'b0;
    end else begin
      pg_oe_n_ff <= all_gate_src_good;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign cold_alarm = cold_ff;
  assign hot_alarm = hot_ff;
  // Open-drain: only ever drives low, so the data output is a constant zero
  assign rail_good_output_o = 1'b0;
  assign rail_good_output_oe_n = pg_oe_n_ff;
endmodule // thermal_threshold_powergood_regs
`default_nettype wire

//--- verification/host_model.sv
// Host model issuing single-byte register requests.
// Assumes the bench calls one task at a time.
`default_nettype none
module host_model import thermal_pg_pkg::*; (
  input wire logic sys_clk,
  output var reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns / 1ps;
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, x};
    @(posedge sys_clk) reg_req <= '{1'b0, 1'b0, ~a, ~x};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x, output logic ok);
    @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge sys_clk) ok = reg_rvalid;
    x = reg_rdata;
  endtask
endmodule // host_model
`default_nettype wire

//--- verification/thermal_threshold_powergood_regs_asserts.sv
// Port assertions for the register bank.
// Bound to the top; rails change only between status reads.
`default_nettype none
module tpg_chk import thermal_pg_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic temp_done,
  input wire logic signed [7:0] temp_value,
  input wire rail_good_t rail_good_async,
  input wire logic cold_alarm,
  input wire logic hot_alarm,
  input wire logic rail_good_output_o,
  input wire logic rail_good_output_oe_n
);
  timeunit 1ns / 1ps;
  wire logic [5:0] r = rail_good_async;
  wire logic four = &{r[4], r[2:0]};
  wire logic [7:0] st = {r[5:1], 1'b0, r[0], 1'b0};
  wire logic rd_st = reg_req.rd && reg_req.addr == STATUS_ADDR;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Eight samples cover the synchroniser and filter delay
  sequence s_hold(x); x [*8]; endsequence
  property p_st; s_hold($stable(r)) ##0 rd_st |=> reg_rdata == $past(st); endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_lo; temp_done && temp_value <= -8'sd7 |=> cold_alarm; endproperty
  a_lo: assert property (p_lo) else $error("no cold alarm");
  property p_hi; temp_done && temp_value >= 8'sd57 |=> hot_alarm; endproperty
  a_hi: assert property (p_hi) else $error("no hot alarm");
  property p_mid; temp_done && temp_value == 8'sd20 |=> !cold_alarm && !hot_alarm; endproperty
  a_mid: assert property (p_mid) else $error("alarm in band");
  property p_q; !temp_done |=> !cold_alarm && !hot_alarm; endproperty
  a_q: assert property (p_q) else $error("stray alarm");
  property p_up; s_hold(four) |-> rail_good_output_oe_n; endproperty
  a_up: assert property (p_up) else $error("pin held");
  property p_dn; s_hold(!four) |-> !rail_good_output_oe_n; endproperty
  a_dn: assert property (p_dn) else $error("pin released");
  property p_drv; !rail_good_output_o; endproperty
  a_drv: assert property (p_drv) else $error("pin high");
endmodule // tpg_chk
bind thermal_threshold_powergood_regs tpg_chk chk_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .temp_done(temp_done),
  .temp_value(temp_value),
  .rail_good_async(rail_good_async),
  .cold_alarm(cold_alarm),
  .hot_alarm(hot_alarm),
  .rail_good_output_o(rail_good_output_o),
  .rail_good_output_oe_n(rail_good_output_oe_n)
);
`default_nettype wire

//--- verification/tb_thermal_threshold_powergood_regs.sv
// Bench for the threshold, rail-good and revision registers.
// Assumes host_model for register traffic; seed fixed at 48.
`default_nettype none
module tb_thermal_threshold_powergood_regs import thermal_pg_pkg::*;;
  timeunit 1ns / 1ps;
  logic sys_clk = 0, rst = 1, temp_done = 0, reg_rvalid, cold_alarm, hot_alarm, v;
  logic rail_good_output_o, rail_good_output_oe_n;
  logic signed [7:0] temp_value = 0;
  logic [7:0] reg_rdata, d, thr;
  logic [5:0] rr;
  int tv;
  rail_good_t rail_good_async = '0;
  reg_req_t reg_req;
  int failures = 0, n_checks = 0;
  integer seed = 48;
  always #5 sys_clk = ~sys_clk;
  thermal_threshold_powergood_regs uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .temp_done(temp_done),
    .temp_value(temp_value),
    .rail_good_async(rail_good_async),
    .cold_alarm(cold_alarm),
    .hot_alarm(hot_alarm),
    .rail_good_output_o(rail_good_output_o),
    .rail_good_output_oe_n(rail_good_output_oe_n)
  );
  host_model host (
    .sys_clk(sys_clk),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("%0d checks, %0d failures", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask
  function automatic logic [8:0] alarms(logic [7:0] th, logic signed [7:0] t);
    return {7'h0, int'(t) >= int'(th[3:0]) + 42, int'(t) <= int'(th[7:4]) - 7};
  endfunction
  function automatic logic [7:0] status_exp(logic [5:0] r);
    return {r[5:1], 1'b0, r[0], 1'b0};
  endfunction
  task automatic temp(input int t);
    @(posedge sys_clk);
    temp_done <= 1'b1;
    temp_value <= 8'(t);
    @(posedge sys_clk) temp_done <= 1'b0;
    @(posedge sys_clk) chk({7'h0, hot_alarm, cold_alarm}, alarms(thr, 8'(t)));
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(THRESH_ADDR, THRESH_RESET);
    rd_chk(SILICON_REVISION_ID_ADDR, 8'h43);
    rd_chk(8'h20, 8'h00);
    chk({8'h0, rail_good_output_oe_n}, 9'h000);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      thr = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      host.wr(THRESH_ADDR, thr);
      host.wr(SILICON_REVISION_ID_ADDR, thr);
      rd_chk(SILICON_REVISION_ID_ADDR, 8'h43);
      rd_chk(THRESH_ADDR, thr);
      // Both edges of each band, then a mid and a random reading
      for (int k = 0; k < 6; k++) begin
        tv = k > 4 ? $random(seed) : k > 3 ? 20 : k < 2 ? thr[7:4] - 7 + k : thr[3:0] + 44 - k;
        temp(tv);
      end
    end
    $display("threshold test done");
    // Reset after writes must bring the thresholds back
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(THRESH_ADDR, THRESH_RESET);
    chk({8'h0, rail_good_output_oe_n}, 9'h000);
    $display("mid-run reset test done");
    for (int i = 0; i < 12; i++) begin
      rr = (i == 0) ? 6'h3f : (i == 1) ? 6'h17 : 6'($random(seed));
      rail_good_async <= rr;
      host.wr(STATUS_ADDR, 8'hff);
      repeat (8) @(posedge sys_clk);
      rd_chk(STATUS_ADDR, status_exp(rr));
      chk({8'h0, rail_good_output_oe_n}, {8'h0, &{rr[4], rr[2:0]}});
    end
    $display("rail test done");
    results();
  end
  initial begin
    #100_000;
    failures++;
    results();
  end
endmodule // tb_thermal_threshold_powergood_regs
`default_nettype wire
